// ### verilog/lcs_consts.svh
/*
 * constants for the cache sram host controller: address widths, pin timing counts.
 * assumes a 25 MHz controller clock (40 ns period).
 */
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

`define LCS_CLK_PERIOD_NS 40
`define LCS_ADDR_W 13
`define LCS_DATA_W 16
`define LCS_TOP_BIT 12
// strobe high time, ns (min)
`define LCS_STROBE_NS 12
// address setup to strobe low, ns (min)
`define LCS_ADDR_SETUP_NS 8
// write enable pulse width, ns (min)
`define LCS_WRITE_PULSE_NS 30
// output enable to data valid plus address access, ns (min wait)
`define LCS_READ_ACCESS_NS 45
`define LCS_CYC(ns) (((ns) + `LCS_CLK_PERIOD_NS - 1) / `LCS_CLK_PERIOD_NS)
`define LCS_STROBE_CYC `LCS_CYC(`LCS_STROBE_NS)
`define LCS_SETUP_CYC `LCS_CYC(`LCS_ADDR_SETUP_NS)
`define LCS_WRITE_CYC `LCS_CYC(`LCS_WRITE_PULSE_NS)
`define LCS_READ_CYC `LCS_CYC(`LCS_READ_ACCESS_NS)
`define LCS_CNT_W 4

`endif

// ### verilog/lcs_pkg.sv
/*
 * types for the cache sram host controller.
 * assumes lcs_consts.svh is included first.
 */
`include "lcs_consts.svh"

package lcs_pkg;

    typedef struct packed {
        logic write;
        logic way_b;
        logic [1:0] lanes;
        logic [`LCS_ADDR_W-1:0] addr;
        logic [`LCS_DATA_W-1:0] wdata;
    } lcs_req_t;

    typedef struct packed {
        logic strobe;
        logic chip_enable_n;
        logic low_byte_select_n;
        logic high_byte_select_n;
        logic way_a_write_n;
        logic way_b_write_n;
        logic way_a_drive_n;
        logic way_b_drive_n;
    } lcs_ctl_t;

    typedef enum logic [2:0] {
        LCS_IDLE,
        LCS_SETUP,
        LCS_LATCH,
        LCS_WRITE,
        LCS_READ,
        LCS_END
    } lcs_state_t;

endpackage : lcs_pkg

// ### verilog/lcs_timer.sv
/*
 * down counter used for pin phase lengths.
 * assumes load and load value come from the same clock domain.
 */
`include "lcs_consts.svh"

module lcs_timer (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic load_in,
    input wire logic [`LCS_CNT_W-1:0] value_in,
    output logic done_out
);
    logic [`LCS_CNT_W-1:0] cnt_q;
    logic [`LCS_CNT_W-1:0] cnt_d;

    assign cnt_d = load_in ? value_in : (cnt_q != '0 ? cnt_q - 4'h1 : cnt_q);
    assign done_out = (cnt_q == 4'h1) && !load_in;

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : lcs_timer

// ### verilog/lcs_host.sv
/*
 * host controller for the 128-kbit latched two-way cache sram.
 * assumes the sram pins are wired straight to the outputs and the data pins are
 * resolved outside from data_oe_n_out; inputs are synchronous to ref_clk_in.
 */
//
// Behaviour
// - two-way mode: top address bit ignored, host drives it low.
// - two-way write: chip enable, byte select and bank write enable low.
// - direct mode: write enables tied together, top bit picks bank.
// - two-way read: chip enable, bank output enable, byte select low; writes high.
// - direct mode: output enables tied together, top bit picks bank.
// - during any read both bank write enables stay high.
// - write data held stable across the write-ending rising edge.

`include "lcs_consts.svh"

module lcs_host (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic two_way_mode_in,
    input wire logic req_valid_in,
    input wire lcs_pkg::lcs_req_t req_in,
    input wire logic [`LCS_DATA_W-1:0] data_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [`LCS_DATA_W-1:0] rsp_data_out,
    output logic mode_out,
    output logic [`LCS_ADDR_W-1:0] addr_out,
    output lcs_pkg::lcs_ctl_t ctl_out,
    output logic [`LCS_DATA_W-1:0] data_out,
    output logic data_oe_n_out
);
    ////////////////////////////////////////////////////////////////
    lcs_pkg::lcs_state_t state_q;
    lcs_pkg::lcs_state_t state_d;
    lcs_pkg::lcs_req_t req_q;
    lcs_pkg::lcs_ctl_t ctl_q;
    lcs_pkg::lcs_ctl_t ctl_d;
    logic [`LCS_ADDR_W-1:0] addr_q;
    logic [`LCS_DATA_W-1:0] wdata_q;
    logic [`LCS_DATA_W-1:0] rsp_data_q;
    logic rsp_valid_q;
    logic ready_q;
    logic mode_q;
    logic oe_n_q;
    logic tmr_load;
    logic [`LCS_CNT_W-1:0] tmr_value;
    logic tmr_done;
    logic take;
    logic [`LCS_ADDR_W-1:0] req_addr;
    logic sel_b;

    ////////////////////////////////////////////////////////////////
    // two-way forces the top bit low; direct uses it as the bank pick
    assign take = (state_q == lcs_pkg::LCS_IDLE) && req_valid_in;
    assign req_addr = two_way_mode_in ?
        {1'b0, req_in.addr[`LCS_TOP_BIT-1:0]} : req_in.addr;
    // direct mode drives both enables alike so the device decodes the top bit
    assign sel_b = req_q.way_b;

    lcs_timer u_timer (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .load_in(tmr_load),
        .value_in(tmr_value),
        .done_out(tmr_done)
    );

    ////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        ctl_d = ctl_q;
        tmr_load = 1'b0;
        tmr_value = 4'h0;
        case (state_q)
            lcs_pkg::LCS_IDLE: begin
                if (req_valid_in) begin
                    // strobe high: latch transparent while address settles
                    ctl_d.strobe = 1'b1;
                    tmr_load = 1'b1;
                    tmr_value = 4'(`LCS_STROBE_CYC + `LCS_SETUP_CYC);
                    state_d = lcs_pkg::LCS_SETUP;
                end
            end
            lcs_pkg::LCS_SETUP: begin
                if (tmr_done) begin
                    // falling strobe captures the address; the TOP_BYPASS variant takes the top bit straight from the pin
                    ctl_d.strobe = 1'b0;
                    state_d = lcs_pkg::LCS_LATCH;
                end
            end
            lcs_pkg::LCS_LATCH: begin
                ctl_d.chip_enable_n = 1'b0;
                ctl_d.low_byte_select_n = !req_q.lanes[0];
                ctl_d.high_byte_select_n = !req_q.lanes[1];
                tmr_load = 1'b1;
                if (req_q.write) begin
                    ctl_d.way_a_write_n = !(!mode_q || !sel_b);
                    ctl_d.way_b_write_n = !(!mode_q || sel_b);
                    tmr_value = 4'(`LCS_WRITE_CYC);
                    state_d = lcs_pkg::LCS_WRITE;
                end else begin
                    // never both low in two-way: that would deselect both banks
                    ctl_d.way_a_drive_n = !(!mode_q || !sel_b);
                    ctl_d.way_b_drive_n = !(!mode_q || sel_b);
                    tmr_value = 4'(`LCS_READ_CYC);
                    state_d = lcs_pkg::LCS_READ;
                end
            end
            lcs_pkg::LCS_WRITE: begin
                if (tmr_done) begin
                    // write enables rise first; data and address still held
                    ctl_d.way_a_write_n = 1'b1;
                    ctl_d.way_b_write_n = 1'b1;
                    state_d = lcs_pkg::LCS_END;
                end
            end
            lcs_pkg::LCS_READ: begin
                if (tmr_done) begin
                    ctl_d.way_a_drive_n = 1'b1;
                    ctl_d.way_b_drive_n = 1'b1;
                    state_d = lcs_pkg::LCS_END;
                end
            end
            lcs_pkg::LCS_END: begin
                // deselect: device floats and blocks writes
                ctl_d.chip_enable_n = 1'b1;
                ctl_d.low_byte_select_n = 1'b1;
                ctl_d.high_byte_select_n = 1'b1;
                state_d = lcs_pkg::LCS_IDLE;
            end
            default: begin
                state_d = lcs_pkg::LCS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q <= lcs_pkg::LCS_IDLE;
            ctl_q <= '{strobe: 1'b0, default: 1'b1};
        end else begin
            state_q <= state_d;
            ctl_q <= ctl_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            req_q <= '0;
            addr_q <= 13'h0000;
            wdata_q <= 16'h0000;
            mode_q <= 1'b1;
        end else if (take) begin
            req_q <= req_in;
            addr_q <= req_addr;
            wdata_q <= req_in.wdata;
            mode_q <= two_way_mode_in;
        end
    end

    // host drives data only for the write phases; released while reading
    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= !(req_q.write && (state_d == lcs_pkg::LCS_WRITE
                || (state_q == lcs_pkg::LCS_WRITE)));
        end
    end

    always_ff @(posedge ref_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 16'h0000;
            ready_q <= 1'b1;
        end else begin
            rsp_valid_q <= (state_q == lcs_pkg::LCS_READ) && tmr_done;
            if ((state_q == lcs_pkg::LCS_READ) && tmr_done) begin
                rsp_data_q <= data_in;
            end
            ready_q <= (state_d == lcs_pkg::LCS_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////
    assign req_ready_out = ready_q;
    assign rsp_valid_out = rsp_valid_q;
    assign rsp_data_out = rsp_data_q;
    assign mode_out = mode_q;
    assign addr_out = addr_q;
    assign ctl_out = ctl_q;
    assign data_out = wdata_q;
    assign data_oe_n_out = oe_n_q;
endmodule : lcs_host

// ### verif/lcs_host_properties.sv
/* pin sequencing checker for the cache sram host.
 * assumes it is bound to lcs_host and sees only its ports. */
`include "lcs_consts.svh"
module lcs_host_chk (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic req_valid_in,
    input wire lcs_pkg::lcs_req_t req_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire logic mode_out,
    input wire logic [`LCS_ADDR_W-1:0] addr_out,
    input wire lcs_pkg::lcs_ctl_t ctl_out,
    input wire logic [`LCS_DATA_W-1:0] data_out,
    input wire logic data_oe_n_out
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!resetn_in);
wire wr_on = !(ctl_out.way_a_write_n & ctl_out.way_b_write_n);
wire rd_on = !(ctl_out.way_a_drive_n & ctl_out.way_b_drive_n);
////////////////////////////////////////////////////////////////
property p_top; mode_out && !ctl_out.chip_enable_n |-> !addr_out[`LCS_TOP_BIT]; endproperty
a_top: assert property (p_top) else $error("top bit high in two-way");
property p_rd_wr; rd_on |-> !wr_on; endproperty
a_rd_wr: assert property (p_rd_wr) else $error("write enable during read");
property p_one; mode_out && rd_on |-> ctl_out.way_a_drive_n != ctl_out.way_b_drive_n; endproperty
a_one: assert property (p_one) else $error("two-way read not one bank");
property p_tie; !mode_out |-> ctl_out.way_a_drive_n == ctl_out.way_b_drive_n
    && ctl_out.way_a_write_n == ctl_out.way_b_write_n; endproperty
a_tie: assert property (p_tie) else $error("direct enables differ");
property p_wr; wr_on |-> !ctl_out.chip_enable_n && !data_oe_n_out; endproperty
a_wr: assert property (p_wr) else $error("write without select or data");
property p_hold; $rose(ctl_out.way_a_write_n) || $rose(ctl_out.way_b_write_n)
    |-> $stable(data_out) && !data_oe_n_out; endproperty
a_hold: assert property (p_hold) else $error("data moved at write end");
property p_lat; $fell(ctl_out.chip_enable_n) |-> !ctl_out.strobe && $stable(addr_out); endproperty
a_lat: assert property (p_lat) else $error("select before latch");
property p_ans; req_valid_in && req_ready_out && !req_in.write |-> ##[4:12] rsp_valid_out; endproperty
a_ans: assert property (p_ans) else $error("read answer missing");
property p_idle; req_ready_out |-> ctl_out.chip_enable_n && !wr_on && !rd_on && data_oe_n_out; endproperty
a_idle: assert property (p_idle) else $error("pins active while idle");
endmodule : lcs_host_chk
bind lcs_host lcs_host_chk chk_u (.ref_clk_in, .resetn_in, .req_valid_in, .req_in, .req_ready_out,
    .rsp_valid_out, .mode_out, .addr_out, .ctl_out, .data_out, .data_oe_n_out);

// ### verif/lcs_sram_model.sv
/* behavioural cache sram device.
 * assumes pins come straight from lcs_host; data bus resolved outside. */
`include "lcs_consts.svh"
module lcs_sram_model #(parameter bit TOP_BYPASS = 1'b0) (
    input wire logic mode_in,
    input wire logic [`LCS_ADDR_W-1:0] addr_in,
    input wire lcs_pkg::lcs_ctl_t ctl_in,
    input wire logic [`LCS_DATA_W-1:0] d_in,
    output logic [`LCS_DATA_W-1:0] q_out,
    output logic [1:0] lane_en_out
);
timeunit 1ns;
timeprecision 1ns;
logic [`LCS_DATA_W-1:0] mem [0:8191];
logic [`LCS_ADDR_W-1:0] lat;
always_latch if (ctl_in.strobe) lat <= addr_in;
wire top = TOP_BYPASS ? addr_in[12] : lat[12];
wire [1:0] lane = {!ctl_in.high_byte_select_n, !ctl_in.low_byte_select_n} & {2{!ctl_in.chip_enable_n}};
wire wr_a = !ctl_in.way_a_write_n & (mode_in | !top);
wire wr_b = !ctl_in.way_b_write_n & (mode_in | top);
wire rd_a = !ctl_in.way_a_drive_n & (mode_in ? ctl_in.way_b_drive_n : !top);
wire rd_b = !ctl_in.way_b_drive_n & (mode_in ? ctl_in.way_a_drive_n : top);
wire no_wr = ctl_in.way_a_write_n & ctl_in.way_b_write_n;
assign lane_en_out = ((rd_a | rd_b) & no_wr) ? lane : 2'h0;
assign q_out = mem[{rd_b, lat[11:0]}];
// level sensitive: any enable going high ends the write
always @(wr_a, wr_b, lane, lat, d_in) begin
    for (int b = 0; b < 2; b++) begin
        if (lane[b] && wr_a) mem[{1'b0, lat[11:0]}][8*b +: 8] = d_in[8*b +: 8];
        if (lane[b] && wr_b) mem[{1'b1, lat[11:0]}][8*b +: 8] = d_in[8*b +: 8];
    end
end
endmodule : lcs_sram_model

// ### verif/testbench.sv
/* self-checking bench for lcs_host with a device model.
 * assumes the checker is bound through its own file. */
`include "lcs_consts.svh"
module testbench;
timeunit 1ns;
timeprecision 1ns;
typedef struct packed {logic mode; lcs_pkg::lcs_req_t req;} lcs_row_t;
logic ref_clk_in = 1'b0;
logic resetn_in = 1'b0;
logic mode = 1'b1;
logic req_valid = 1'b0;
lcs_pkg::lcs_req_t req = '0;
logic req_ready, rsp_valid, mode_pin, data_oe_n;
logic [15:0] rsp_data, data_out, data_in, q;
logic [12:0] addr;
logic [1:0] en;
lcs_pkg::lcs_ctl_t ctl;
int miscompares = 0;
int compares = 0;
lcs_row_t rows [10];
always #20 ref_clk_in = ~ref_clk_in;
// released byte lanes show the inverse so stale data never matches
assign data_in = !data_oe_n ? data_out : {en[1] ? q[15:8] : ~q[15:8], en[0] ? q[7:0] : ~q[7:0]};
lcs_host dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .two_way_mode_in(mode),
    .req_valid_in(req_valid), .req_in(req), .data_in(data_in), .req_ready_out(req_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .mode_out(mode_pin), .addr_out(addr),
    .ctl_out(ctl), .data_out(data_out), .data_oe_n_out(data_oe_n));
lcs_sram_model mem_u (.mode_in(mode_pin), .addr_in(addr), .ctl_in(ctl), .d_in(data_out),
    .q_out(q), .lane_en_out(en));
////////////////////////////////////////////////////////////////
task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
        miscompares++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask : chk
task conclude;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
endtask : conclude
// reads carry their expected word in wdata
task run(input lcs_row_t r);
    logic [15:0] m;
    m = {{8{r.req.lanes[1]}}, {8{r.req.lanes[0]}}};
    @(posedge ref_clk_in);
    mode <= r.mode;
    req <= r.req;
    req_valid <= 1'b1;
    @(posedge ref_clk_in);
    req_valid <= 1'b0;
    @(negedge ref_clk_in);
    if (!r.req.write) begin
        for (int i = 0; i < 20 && rsp_valid !== 1'b1; i++) @(negedge ref_clk_in);
        chk({15'h0, rsp_valid}, 16'h0001);
        chk(rsp_data & m, r.req.wdata & m);
    end
    for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(negedge ref_clk_in);
    // a host that never comes back to idle must count, not slip through
    chk({15'h0, req_ready}, 16'h0001);
endtask : run
initial begin
    rows[0] = {1'h1, 1'h1, 1'h0, 2'h3, 13'h0010, 16'hffff};
    rows[1] = {1'h1, 1'h1, 1'h1, 2'h3, 13'h0010, 16'h1234};
    rows[2] = {1'h1, 1'h0, 1'h0, 2'h3, 13'h0010, 16'hffff};
    rows[3] = {1'h1, 1'h0, 1'h1, 2'h3, 13'h0010, 16'h1234};
    rows[4] = {1'h1, 1'h1, 1'h0, 2'h1, 13'h0010, 16'h00aa};
    rows[5] = {1'h1, 1'h0, 1'h0, 2'h3, 13'h1010, 16'hffaa};
    rows[6] = {1'h0, 1'h1, 1'h0, 2'h2, 13'h1010, 16'h5500};
    rows[7] = {1'h0, 1'h0, 1'h0, 2'h3, 13'h1010, 16'h5534};
    rows[8] = {1'h0, 1'h0, 1'h1, 2'h3, 13'h0010, 16'hffaa};
    rows[9] = {1'h1, 1'h0, 1'h1, 2'h2, 13'h0010, 16'h5534};
    repeat (5) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    foreach (rows[k]) run(rows[k]);
    $display("test rows done");
    @(posedge ref_clk_in);
    req <= {1'h1, 1'h0, 2'h3, 13'h0030, 16'h0000};
    req_valid <= 1'b1;
    @(posedge ref_clk_in);
    req_valid <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    @(negedge ref_clk_in);
    chk({8'h00, ctl}, 16'h007f);
    chk({13'h0, data_oe_n, req_ready, mode_pin}, 16'h0007);
    @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    // model memory survives host reset: bank a word is ffaa from the rows
    // no byte lane selected: this write must leave the word alone
    run({1'h1, 1'h1, 1'h0, 2'h0, 13'h0010, 16'h0000});
    run(rows[5]);
    $display("test reset done");
    conclude();
end
initial begin
    #100000;
    miscompares++;
    conclude();
end
endmodule : testbench
